/* File: pkg/wwdt_consts.vh */
// Constants for the windowed watchdog timer: address, keys, option byte fields and counter sizes.
`ifndef WWDT_CONSTS_VH
`define WWDT_CONSTS_VH

// Register address of the watchdog service register.
`define WWDT_SERVICE_ADDR      20'hfffab
`define WWDT_ADDR_W            20

// Service key and the two read-back values.
`define WWDT_SERVICE_KEY       8'hac
`define WWDT_RDVAL_ENABLED     8'h9a
`define WWDT_RDVAL_DISABLED    8'h1a

// Option byte field positions.
`define WWDT_OPT_INTERVAL_BIT  7
`define WWDT_OPT_WIN_HI_BIT    6
`define WWDT_OPT_WIN_LO_BIT    5
`define WWDT_OPT_ENABLE_BIT    4
`define WWDT_OPT_OVF_HI_BIT    3
`define WWDT_OPT_OVF_LO_BIT    1
`define WWDT_OPT_STANDBY_BIT   0

// Overflow time as a power of two of low-speed clock cycles, per select code.
`define WWDT_OVF_EXP0          5'd10
`define WWDT_OVF_EXP1          5'd11
`define WWDT_OVF_EXP2          5'd12
`define WWDT_OVF_EXP3          5'd13
`define WWDT_OVF_EXP4          5'd15
`define WWDT_OVF_EXP5          5'd17
`define WWDT_OVF_EXP6          5'd18
`define WWDT_OVF_EXP7          5'd20

// Counter width covers the longest overflow time.
`define WWDT_CNT_W             21

// Window size codes.
`define WWDT_WIN_25            2'h0
`define WWDT_WIN_50            2'h1
`define WWDT_WIN_75            2'h2
`define WWDT_WIN_100           2'h3

`endif

/* File: core/wwdt_core.v */
// Windowed watchdog timer: low-speed counter, service register, window check and reset request.
`timescale 1ns/1ps
//
// Function
// - Counter advances only on low-speed oscillator edges, not on the system clock.
// - Counter reaching the selected overflow time without service requests internal reset.
// - A single-bit manipulation access to the service register requests internal reset.
// - Writing any value other than ACH to the service register requests reset.
// - A service write while the window is closed requests reset, even with ACH.
// - A watchdog-caused reset sets the watchdog reset cause flag, cause register bit 4.
// - When selected, interval interrupt fires at 75% of the overflow time.
// - Option byte: bit7 interval, bits6-5 window, bit4 enable, bits3-1 overflow, bit0 standby.
// - Writing ACH clears the counter to zero and counting resumes.
// - Service register resets to 9AH when counting is enabled, otherwise 1AH.
// - Reads always return 9AH or 1AH, never the value last written.
// - Enable bit 0 keeps the counter stopped; 1 starts counting at reset release.
// - Overflow select codes 0..7 give 2^10,11,12,13,15,17,18,20 low-speed cycles.
// - Window codes 00..11 open the final 25, 50, 75 or 100 percent.
// - First service write after reset release restarts the counter, ignoring the window.
// - Standby bit 0: counter stops in HALT/STOP, restarts at zero, window fully open.
`include "wwdt_consts.vh"

// The counter lives in the system clock domain and advances on a one-cycle tick taken
// from the synchronised low-speed oscillator, so no second clock reaches the logic.
// A reset request sets rst_done_r, which freezes the counter and masks further requests
// until the system reset arrives, keeping the request to a single pulse per reset period.
// The cause flag has its own power-on reset so that the watchdog's reset leaves it set.

module wwdt_core (
  input  wire                    i_clk_sys,
  input  wire                    i_sys_rst,
  input  wire                    i_por_rst,
  input  wire [7:0]              i_option_byte,
  input  wire                    i_losc_clk,
  input  wire                    i_standby,
  input  wire [`WWDT_ADDR_W-1:0] i_reg_addr,
  input  wire                    i_reg_wr,
  input  wire                    i_reg_bit_op,
  input  wire                    i_reg_rd,
  input  wire [7:0]              i_reg_wdata,
  input  wire                    i_cause_clr,
  output wire [7:0]              o_reg_rdata,
  output wire                    o_rst_req,
  output wire                    o_interval_interrupt,
  output wire                    o_watchdog_reset_cause_flag
);

  // Captured option byte, synchroniser stages, counter and output registers.
  reg [7:0]               opt_r;
  reg                     opt_valid_r;
  reg                     losc_s1_r;
  reg                     losc_s2_r;
  reg                     losc_s3_r;
  reg [`WWDT_CNT_W-1:0]   cnt_r;
  reg [`WWDT_CNT_W-1:0]   cnt_nxt;
  reg                     first_pending_r;
  reg                     rst_req_r;
  reg                     rst_done_r;
  reg                     irq_r;
  reg                     cause_r;
  reg [7:0]               rdata_r;
  reg [4:0]               ovf_exp;
  reg [`WWDT_CNT_W-1:0]   close_thr;
  reg                     irq_nxt;
  reg                     fault;

  // Decoded option fields and per-cycle decisions.
  wire                    losc_tick;
  wire                    counting;
  wire                    standby_stop;
  wire                    win_open;
  wire                    svc_access;
  wire [`WWDT_CNT_W-1:0]  limit;
  wire [`WWDT_CNT_W-1:0]  quarter;
  wire [`WWDT_CNT_W-1:0]  irq_point;
  wire [7:0]              reset_value;

  // The option byte is caught on the first clock after reset release, never under reset itself.
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      opt_r       <= 8'h00;
      opt_valid_r <= 1'b0;
    end else if (!opt_valid_r) begin
      opt_r       <= i_option_byte;
      opt_valid_r <= 1'b1;
    end
  end

  // The low-speed oscillator is another domain: two flip-flops, then an edge detector on the second.
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      losc_s1_r <= 1'b0;
      losc_s2_r <= 1'b0;
      losc_s3_r <= 1'b0;
    end else begin
      losc_s1_r <= i_losc_clk;
      losc_s2_r <= losc_s1_r;
      losc_s3_r <= losc_s2_r;
    end
  end

  // One-cycle tick on each rising low-speed edge.
  assign losc_tick = losc_s2_r & ~losc_s3_r;

  // Overflow exponent decoded from the three select bits.
  always @* begin
    case (opt_r[`WWDT_OPT_OVF_HI_BIT:`WWDT_OPT_OVF_LO_BIT])
      3'h0:    ovf_exp = `WWDT_OVF_EXP0;
      3'h1:    ovf_exp = `WWDT_OVF_EXP1;
      3'h2:    ovf_exp = `WWDT_OVF_EXP2;
      3'h3:    ovf_exp = `WWDT_OVF_EXP3;
      3'h4:    ovf_exp = `WWDT_OVF_EXP4;
      3'h5:    ovf_exp = `WWDT_OVF_EXP5;
      3'h6:    ovf_exp = `WWDT_OVF_EXP6;
      default: ovf_exp = `WWDT_OVF_EXP7;
    endcase
  end

  // Overflow limit, its quarter and the 75 percent point for the interval interrupt.
  assign limit     = {{(`WWDT_CNT_W-1){1'b0}}, 1'b1} << ovf_exp;
  assign quarter   = limit >> 2;
  assign irq_point = limit - quarter;

  // Closed window ends where the open part of the period begins.
  always @* begin
    case ({opt_r[`WWDT_OPT_WIN_HI_BIT], opt_r[`WWDT_OPT_WIN_LO_BIT]})
      `WWDT_WIN_25: close_thr = limit - quarter;
      `WWDT_WIN_50: close_thr = limit >> 1;
      `WWDT_WIN_75: close_thr = quarter;
      default:      close_thr = {`WWDT_CNT_W{1'b0}};
    endcase
  end

  // Counting state and window decision.
  assign counting     = opt_valid_r & opt_r[`WWDT_OPT_ENABLE_BIT];
  assign standby_stop = i_standby & ~opt_r[`WWDT_OPT_STANDBY_BIT];
  assign win_open     = first_pending_r | ~opt_r[`WWDT_OPT_STANDBY_BIT] | (cnt_r >= close_thr);
  assign svc_access   = opt_valid_r & i_reg_wr & (i_reg_addr == `WWDT_SERVICE_ADDR);
  assign reset_value  = opt_r[`WWDT_OPT_ENABLE_BIT] ? `WWDT_RDVAL_ENABLED : `WWDT_RDVAL_DISABLED;

  // Next counter value, fault detection and interval interrupt decision.
  always @* begin
    cnt_nxt = cnt_r;
    fault   = 1'b0;
    irq_nxt = 1'b0;
    // A service write takes priority over a tick in the same cycle.
    if (svc_access) begin
      if (i_reg_bit_op) begin
        fault = 1'b1;
      end else if (i_reg_wdata != `WWDT_SERVICE_KEY) begin
        fault = 1'b1;
      end else if (!win_open) begin
        fault = 1'b1;
      end else begin
        cnt_nxt = {`WWDT_CNT_W{1'b0}};
      end
    end else if (counting && standby_stop) begin
      cnt_nxt = {`WWDT_CNT_W{1'b0}};
    end else if (counting && losc_tick) begin
      if (cnt_r == limit - {{(`WWDT_CNT_W-1){1'b0}}, 1'b1}) begin
        fault = 1'b1;
      end else begin
        cnt_nxt = cnt_r + {{(`WWDT_CNT_W-1){1'b0}}, 1'b1};
        irq_nxt = opt_r[`WWDT_OPT_INTERVAL_BIT] &&
                  (cnt_r + {{(`WWDT_CNT_W-1){1'b0}}, 1'b1} == irq_point);
      end
    end
  end

  // Counter, first-write marker and the single reset request pulse.
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      cnt_r           <= {`WWDT_CNT_W{1'b0}};
      first_pending_r <= 1'b1;
      rst_req_r       <= 1'b0;
      rst_done_r      <= 1'b0;
      irq_r           <= 1'b0;
    end else begin
      irq_r     <= irq_nxt & ~rst_done_r;
      rst_req_r <= fault & ~rst_done_r;
      if (fault) begin
        rst_done_r <= 1'b1;
      end
      // After a request the counter holds its value until the system reset.
      if (!rst_done_r) begin
        cnt_r <= cnt_nxt;
      end
      if (svc_access && !fault) begin
        first_pending_r <= 1'b0;
      end
    end
  end

  // Cause flag survives the watchdog's own reset; set wins over a software clear.
  always @(posedge i_clk_sys) begin
    if (i_por_rst) begin
      cause_r <= 1'b0;
    end else if (rst_req_r) begin
      cause_r <= 1'b1;
    end else if (i_cause_clr) begin
      cause_r <= 1'b0;
    end
  end

  // Read data shows the reset value only, whatever was written.
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rdata_r <= 8'h00;
    end else if (i_reg_rd && opt_valid_r && i_reg_addr == `WWDT_SERVICE_ADDR) begin
      rdata_r <= reset_value;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign o_reg_rdata                 = rdata_r;
  assign o_rst_req                   = rst_req_r;
  assign o_interval_interrupt        = irq_r;
  assign o_watchdog_reset_cause_flag = cause_r;

endmodule // wwdt_core

/* File: testbench/wwdt_core_assertions.sv */
// Concurrent checks on the watchdog core ports.
`timescale 1ns/1ps
`include "wwdt_consts.vh"
module wwdt_checker (
  input wire                    i_clk_sys,
  input wire                    i_sys_rst,
  input wire                    i_por_rst,
  input wire                    i_losc_clk,
  input wire                    i_standby,
  input wire                    i_reg_wr,
  input wire                    i_reg_bit_op,
  input wire                    i_reg_rd,
  input wire                    i_cause_clr,
  input wire [7:0]              i_option_byte,
  input wire [7:0]              i_reg_wdata,
  input wire [7:0]              o_reg_rdata,
  input wire [`WWDT_ADDR_W-1:0] i_reg_addr,
  input wire                    o_rst_req,
  input wire                    o_interval_interrupt,
  input wire                    o_watchdog_reset_cause_flag
);
  reg  cap_r;
  reg  dead_r;
  wire hit = i_reg_wr && (i_reg_addr == `WWDT_SERVICE_ADDR);
  wire ok  = cap_r && !dead_r && !o_rst_req;
  // Marks that the option byte has been captured and whether a reset request has already gone out.
  always @(posedge i_clk_sys) begin
    cap_r  <= !i_sys_rst;
    dead_r <= !i_sys_rst && (dead_r || o_rst_req);
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  property p_bit; ok && hit && i_reg_bit_op |=> o_rst_req; endproperty
  a_bit: assert property (p_bit) else $error("bit access");
  property p_key; ok && hit && i_reg_wdata != `WWDT_SERVICE_KEY |=> o_rst_req; endproperty
  a_key: assert property (p_key) else $error("bad key");
  property p_rd; cap_r && i_reg_rd && i_reg_addr == `WWDT_SERVICE_ADDR
    |=> o_reg_rdata == (i_option_byte[4] ? `WWDT_RDVAL_ENABLED : `WWDT_RDVAL_DISABLED); endproperty
  a_rd: assert property (p_rd) else $error("read value");
  property p_dead; dead_r |-> !o_rst_req && !o_interval_interrupt; endproperty
  a_dead: assert property (p_dead) else $error("extra pulse");
  property p_flag; o_rst_req |=> o_watchdog_reset_cause_flag; endproperty
  a_flag: assert property (p_flag) else $error("cause flag");
  property p_off; !i_option_byte[4] && !$past(i_reg_wr) |-> !o_rst_req; endproperty
  a_off: assert property (p_off) else $error("counted while off");
  property p_noint; !i_option_byte[7] |-> !o_interval_interrupt; endproperty
  a_noint: assert property (p_noint) else $error("interrupt off");
  property p_stby; i_standby && $past(i_standby) && $past(i_standby, 2) && !i_option_byte[0]
    && !$past(i_reg_wr) |-> !o_rst_req; endproperty
  a_stby: assert property (p_stby) else $error("standby");
  c_int: cover property (o_interval_interrupt);
  c_ovf: cover property (o_rst_req && !$past(i_reg_wr));
  c_rd: cover property (i_reg_rd ##1 o_reg_rdata != 8'h00);
endmodule // wwdt_checker

bind wwdt_core wwdt_checker wwdt_checker_inst (
  .i_clk_sys                   (i_clk_sys),
  .i_sys_rst                   (i_sys_rst),
  .i_por_rst                   (i_por_rst),
  .i_losc_clk                  (i_losc_clk),
  .i_standby                   (i_standby),
  .i_reg_wr                    (i_reg_wr),
  .i_reg_bit_op                (i_reg_bit_op),
  .i_reg_rd                    (i_reg_rd),
  .i_cause_clr                 (i_cause_clr),
  .i_option_byte               (i_option_byte),
  .i_reg_wdata                 (i_reg_wdata),
  .o_reg_rdata                 (o_reg_rdata),
  .i_reg_addr                  (i_reg_addr),
  .o_rst_req                   (o_rst_req),
  .o_interval_interrupt        (o_interval_interrupt),
  .o_watchdog_reset_cause_flag (o_watchdog_reset_cause_flag)
);

/* File: testbench/tb_top.sv */
// Self-checking testbench for the windowed watchdog timer core.
`timescale 1ns/1ps
`include "wwdt_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
module tb_top;
  logic                    i_clk_sys = 0, i_sys_rst = 1, i_por_rst = 1, i_losc_clk = 0, i_standby = 0;
  logic                    i_reg_wr = 0, i_reg_bit_op = 0, i_reg_rd = 0, i_cause_clr = 0;
  logic [7:0]              i_option_byte = 8'h10, i_reg_wdata = 8'h00;
  logic [`WWDT_ADDR_W-1:0] i_reg_addr = `WWDT_SERVICE_ADDR;
  wire  [7:0]              o_reg_rdata;
  wire                     o_rst_req, o_interval_interrupt, o_watchdog_reset_cause_flag;
  int                      n_fail = 0, num_checks = 0, cyc = 0, nrq = 0, trq = 0, tirq = 0, c, d, v;
  localparam logic [19:0]  SVC = `WWDT_SERVICE_ADDR;
  localparam logic [7:0]   KEY = `WWDT_SERVICE_KEY;
  wwdt_core wwdt_core_inst (
    .i_clk_sys                   (i_clk_sys),
    .i_sys_rst                   (i_sys_rst),
    .i_por_rst                   (i_por_rst),
    .i_option_byte               (i_option_byte),
    .i_losc_clk                  (i_losc_clk),
    .i_standby                   (i_standby),
    .i_reg_addr                  (i_reg_addr),
    .i_reg_wr                    (i_reg_wr),
    .i_reg_bit_op                (i_reg_bit_op),
    .i_reg_rd                    (i_reg_rd),
    .i_reg_wdata                 (i_reg_wdata),
    .i_cause_clr                 (i_cause_clr),
    .o_reg_rdata                 (o_reg_rdata),
    .o_rst_req                   (o_rst_req),
    .o_interval_interrupt        (o_interval_interrupt),
    .o_watchdog_reset_cause_flag (o_watchdog_reset_cause_flag)
  );
  always #2.5 i_clk_sys = ~i_clk_sys;
  // Low-speed clock at an eighth of the system rate; logs request and interrupt pulses.
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) i_losc_clk <= ~i_losc_clk;
    if (i_sys_rst) nrq <= 0;
    else if (o_rst_req === 1'b1) begin nrq <= nrq + 1; trq <= cyc; end
    if (o_interval_interrupt === 1'b1) tirq <= cyc;
  end
  // Expected read value and overflow length in low-speed ticks.
  function automatic logic [7:0] rdv(input logic [7:0] o);
    return o[4] ? `WWDT_RDVAL_ENABLED : `WWDT_RDVAL_DISABLED;
  endfunction
  function automatic int ticks(input int code);
    int e[8] = '{10, 11, 12, 13, 15, 17, 18, 20};
    return 1 << e[code];
  endfunction
  // Closed part of the shortest overflow period, in ticks, for a window code.
  function automatic int wclose(input int w);
    return ticks(0) * (3 - w) / 4;
  endfunction
  // Applies a new option byte across a reset of n cycles.
  task automatic boot(input logic [7:0] o, input int n);
    i_option_byte <= o;
    i_sys_rst <= 1;
    repeat (n) @(posedge i_clk_sys);
    i_sys_rst <= 0;
    i_por_rst <= 0;
    repeat (3) @(posedge i_clk_sys);
  endtask
  // One register access, 8-bit or single-bit as b selects; returns just after the taking edge, while the answer stands.
  task automatic acc(input logic w, b, input logic [19:0] a, input logic [7:0] dv);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= dv;
    i_reg_wr <= w;
    i_reg_rd <= !w;
    i_reg_bit_op <= b;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
    i_reg_bit_op <= 1'b0;
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence.
  initial begin
    v = $urandom(62);
    // Standby counting on, so the 25 percent window is really in force.
    boot(8'h11, 8);
    acc(1'b0, 1'b0, SVC, 8'h00); `CHK(o_reg_rdata, rdv(i_option_byte))
    acc(1'b0, 1'b0, SVC + 20'h00001, 8'h00); `CHK(o_reg_rdata, 8'h00)
    acc(1'b1, 1'b0, SVC, KEY); `CHK(o_rst_req, 1'b0)
    acc(1'b0, 1'b0, SVC, 8'h00); `CHK(o_reg_rdata, rdv(i_option_byte))
    acc(1'b1, 1'b0, SVC, KEY); `CHK(o_rst_req, 1'b1)
    @(posedge i_clk_sys);
    #1 `CHK(o_watchdog_reset_cause_flag, 1'b1)
    @(posedge i_clk_sys);
    i_cause_clr <= 1'b1;
    @(posedge i_clk_sys);
    i_cause_clr <= 1'b0;
    @(posedge i_clk_sys);
    #1 `CHK(o_watchdog_reset_cause_flag, 1'b0)
    acc(1'b1, 1'b0, SVC, 8'h00); `CHK(o_rst_req, 1'b0)
    @(posedge i_clk_sys);
    #1 `CHK(nrq, 1)
    // Random wrong keys, one hand-picked near miss, then a bit access with the right key.
    for (c = 0; c < 4; c++) begin
      boot(8'h71, 2);
      v = $urandom_range(255);
      if (v[7:0] == KEY) v = 8'h55;
      if (c == 0) v = 8'had;
      if (c < 3) begin
        acc(1'b1, 1'b0, SVC, v[7:0]); `CHK(o_rst_req, 1'b1)
      end else begin
        acc(1'b1, 1'b1, SVC, KEY); `CHK(o_rst_req, 1'b1)
      end
    end
    boot(8'h71, 2);
    repeat (3) begin
      acc(1'b1, 1'b0, SVC, KEY); `CHK(o_rst_req, 1'b0)
    end
    // 50 and 75 percent windows: a key just before the window opens faults, just after clears.
    for (c = 1; c < 3; c++) begin
      for (d = 0; d < 2; d++) begin
        boot({1'b0, c[1:0], 1'b1, 3'h0, 1'b1}, 2);
        acc(1'b1, 1'b0, SVC, KEY);
        repeat (8 * (wclose(c) + (d == 0 ? -64 : 64))) @(posedge i_clk_sys);
        acc(1'b1, 1'b0, SVC, KEY); `CHK(o_rst_req, d == 0)
      end
      repeat (8 * (ticks(0) - wclose(c))) @(posedge i_clk_sys);
      `CHK(nrq, 0)
    end
    for (c = 0; c < 2; c++) begin
      boot({4'h9, c[2:0], 1'b1}, 2);
      for (d = 0; d < ticks(c) * 9 && nrq == 0; d++) @(posedge i_clk_sys);
      #1 `CHK(trq - tirq, ticks(c) * 2)
      `CHK(d > ticks(c) * 8 - 16 && d < ticks(c) * 8 + 16, 1'b1)
      `CHK(nrq, 1)
    end
    boot(8'h00, 2);
    acc(1'b0, 1'b0, SVC, 8'h00); `CHK(o_reg_rdata, rdv(i_option_byte))
    repeat (ticks(0) * 9) @(posedge i_clk_sys);
    `CHK(nrq, 0)
    boot(8'h90, 2);
    i_standby <= 1'b1;
    repeat (ticks(0) * 9) @(posedge i_clk_sys);
    #1 `CHK(nrq, 0)
    finish_test;
  end
  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge i_clk_sys);
    n_fail++;
    finish_test;
  end
endmodule // tb_top
